/* cdi_decoder.sv */
// Character display instruction decoder with AHB-Lite register access
//
// Behaviour
// - Line one 00-13, line two 40-53
// - Line three 14-27, line four 54-67
// - Latch transfer, then run selected operation
// - Busy reads one on bit seven
// - Clear fills spaces, counter to zero
// - Clear homes cursor, forces increment
// - Home zeroes counter, undoes display shift
// - Entry mode: direction and scroll bits
// - Increment steps cursor right, counter up
// - Decrement steps cursor left
// - Glyph memory steps like display memory
// - Scroll only on display memory writes
// - Control: display, cursor, blink enables
// - Cursor off keeps direction setting
// - Blink alternates all ones and character
// - Shift command: select and direction bits
// - Shift codes: cursor or whole display
// - Two-line: wrap to second line after forty
// - Display shift all lines, counter unchanged
// - Width bit: eight or four bit bus
// - Line bit: one or two lines
// - Font bit: five by seven or ten
// - Function set decode, bits four to two
// - Status: busy bit seven, counter below
// - Four-bit: upper lines, high nibble first
// - Select zero command, one data
//
// Local design decisions: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "cdi_regs.svh"
`default_nettype none

module cdi_decoder #(
    parameter int unsigned T_CLEAR_CYC = (`CDI_T_CLEAR_NS + `CDI_CLK_PERIOD_NS - 1)
        / `CDI_CLK_PERIOD_NS,
    parameter int unsigned T_SHORT_CYC = (`CDI_T_SHORT_NS + `CDI_CLK_PERIOD_NS - 1)
        / `CDI_CLK_PERIOD_NS,
    parameter int unsigned T_DATA_CYC = (`CDI_T_DATA_NS + `CDI_CLK_PERIOD_NS - 1)
        / `CDI_CLK_PERIOD_NS,
    parameter int unsigned T_BLINK_CYC = `CDI_T_BLINK_NS / `CDI_CLK_PERIOD_NS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    logic wr_pend_q;
    logic [7:0] addr_q;
    logic [3:0] nib_hi_q;
    logic nib_ph_q;
    logic busy_q;
    logic [31:0] busy_cnt_q;
    logic [6:0] address_counter_q;
    logic glyph_sel_q;
    logic step_up_q;
    logic scroll_on_entry_q;
    logic disp_on_q;
    logic cur_on_q;
    logic blink_on_q;
    logic bus_width_bit_q;
    logic two_line_q;
    logic font_q;
    logic [5:0] shift_q;
    logic [31:0] blink_cnt_q;
    logic blink_ph_q;
    logic [7:0] character_display_memory_q [128];
    logic [7:0] glyph_pattern_memory_q [64];
    logic [31:0] hrdata_q;
    logic cmd_wr;
    logic exec;
    logic [7:0] full_byte;
    cdi_pkg::cdi_cmd_t cmd;
    logic addr_take;
    logic rd_take;
    logic status_rd;
    logic data_rd;
    logic data_rd_exec;
    logic [7:0] mem_at_ac;
    logic [7:0] status_byte;
    logic [7:0] shown_char;
    logic [7:0] cursor_pos;
    logic [7:0] rd_byte;
    // Classify one whole byte by its highest set bit
    function automatic cdi_pkg::cdi_cmd_t decode_cmd(input logic [7:0] b, input logic sel);
        cdi_pkg::cdi_cmd_t k;
        k = cdi_pkg::CDI_CMD_NONE;
        if (sel) begin
            k = cdi_pkg::CDI_CMD_DATA_WRITE;
        end else if (b[7]) begin
            k = cdi_pkg::CDI_CMD_DISP_ADDR;
        end else if (b[6]) begin
            k = cdi_pkg::CDI_CMD_GLYPH_ADDR;
        end else if (b[5]) begin
            k = cdi_pkg::CDI_CMD_FUNCTION;
        end else if (b[4]) begin
            k = cdi_pkg::CDI_CMD_SHIFT;
        end else if (b[3]) begin
            k = cdi_pkg::CDI_CMD_CONTROL;
        end else if (b[2]) begin
            k = cdi_pkg::CDI_CMD_ENTRY;
        end else if (b[1]) begin
            k = cdi_pkg::CDI_CMD_HOME;
        end else if (b[0]) begin
            k = cdi_pkg::CDI_CMD_CLEAR;
        end
        return k;
    endfunction : decode_cmd

    // One address step, with line wrap in display memory
    function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
            input logic two, input logic glyph);
        logic [6:0] n;
        n = up ? a + 7'd1 : a - 7'd1;
        if (glyph) begin
            n = {1'b0, n[5:0]};
        end else if (two) begin
            if (up && a == `CDI_LINE1_LAST) begin
                n = `CDI_LINE2_FIRST;
            end else if (up && a == `CDI_LINE2_LAST) begin
                n = `CDI_HOME_ADDR;
            end else if (!up && a == `CDI_LINE2_FIRST) begin
                n = `CDI_LINE1_LAST;
            end else if (!up && a == `CDI_HOME_ADDR) begin
                n = `CDI_LINE2_LAST;
            end
        end else if (up && a == `CDI_ONE_LINE_LAST) begin
            n = `CDI_HOME_ADDR;
        end else if (!up && a == `CDI_HOME_ADDR) begin
            n = `CDI_ONE_LINE_LAST;
        end
        return n;
    endfunction : ac_step
    // Whole-display offset, moved left or right by one
    function automatic logic [5:0] shift_step(input logic [5:0] s, input logic left);
        return left ? ((s == `CDI_SHIFT_LAST) ? 6'd0 : s + 6'd1)
            : ((s == 6'd0) ? `CDI_SHIFT_LAST : s - 6'd1);
    endfunction : shift_step
    // Screen row and column of a display address, bit 7 set when on screen
    function automatic logic [7:0] screen_pos(input logic [6:0] a);
        logic [7:0] p;
        p = 8'h00;
        if (a < `CDI_ROW2_BASE) begin
            p = {1'b1, 2'd0, 5'(a - `CDI_ROW0_BASE)};
        end else if (a >= `CDI_ROW1_BASE && a < `CDI_ROW3_BASE) begin
            p = {1'b1, 2'd1, 5'(a - `CDI_ROW1_BASE)};
        end else if (a >= `CDI_ROW2_BASE && a <= `CDI_LINE1_LAST) begin
            p = {1'b1, 2'd2, 5'(a - `CDI_ROW2_BASE)};
        end else if (a >= `CDI_ROW3_BASE && a <= `CDI_LINE2_LAST) begin
            p = {1'b1, 2'd3, 5'(a - `CDI_ROW3_BASE)};
        end
        return p;
    endfunction : screen_pos
    assign full_byte = bus_width_bit_q ? hwdata[7:0] : {nib_hi_q, hwdata[7:4]};
    // Command and data transfers arriving while busy are dropped; the host must poll first
    assign cmd_wr = wr_pend_q && !busy_q
        && (addr_q == `CDI_OFS_INSTR || addr_q == `CDI_OFS_DATA);
    assign exec = cmd_wr && (bus_width_bit_q || nib_ph_q);
    assign cmd = exec ? decode_cmd(full_byte, addr_q == `CDI_OFS_DATA) : cdi_pkg::CDI_CMD_NONE;
    assign addr_take = hsel && htrans[1] && hready;
    assign rd_take = addr_take && !hwrite && haddr[31:8] == 24'h000000;
    assign status_rd = rd_take && haddr[7:0] == `CDI_OFS_INSTR;
    assign data_rd = rd_take && haddr[7:0] == `CDI_OFS_DATA && !busy_q && !cmd_wr;
    assign data_rd_exec = data_rd && (bus_width_bit_q || nib_ph_q);
    assign mem_at_ac = glyph_sel_q ? glyph_pattern_memory_q[address_counter_q[5:0]]
        : character_display_memory_q[address_counter_q];
    assign status_byte = {busy_q, address_counter_q};
    assign rd_byte = status_rd ? status_byte : mem_at_ac;
    assign shown_char = (blink_on_q && blink_ph_q) ? 8'hff
        : character_display_memory_q[address_counter_q];
    assign cursor_pos = screen_pos(address_counter_q);
    // Address phase capture; writes complete in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_take && hwrite && haddr[31:8] == 24'h000000;
            addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nib_ph_q <= 1'b0;
            nib_hi_q <= 4'h0;
        end else begin
            if (cmd_wr && !nib_ph_q) begin
                nib_hi_q <= hwdata[7:4];
            end
            if (bus_width_bit_q || (exec && cmd == cdi_pkg::CDI_CMD_FUNCTION && full_byte[4])) begin
                nib_ph_q <= 1'b0;
            end else begin
                nib_ph_q <= nib_ph_q ^ (cmd_wr ^ (status_rd || data_rd));
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_q <= 1'b0;
            busy_cnt_q <= 32'd0;
        end else if (exec || data_rd_exec) begin
            busy_q <= 1'b1;
            if (cmd == cdi_pkg::CDI_CMD_CLEAR || cmd == cdi_pkg::CDI_CMD_HOME) begin
                busy_cnt_q <= T_CLEAR_CYC;
            end else if (cmd == cdi_pkg::CDI_CMD_DATA_WRITE || data_rd_exec) begin
                busy_cnt_q <= T_DATA_CYC;
            end else begin
                busy_cnt_q <= T_SHORT_CYC;
            end
        end else if (busy_cnt_q != 32'd0) begin
            busy_cnt_q <= busy_cnt_q - 32'd1;
            busy_q <= busy_cnt_q > 32'd1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            address_counter_q <= `CDI_HOME_ADDR;
            glyph_sel_q <= 1'b0;
            step_up_q <= 1'b1;
            scroll_on_entry_q <= 1'b0;
            disp_on_q <= 1'b0;
            cur_on_q <= 1'b0;
            blink_on_q <= 1'b0;
            bus_width_bit_q <= 1'b1;
            two_line_q <= 1'b0;
            font_q <= 1'b0;
            shift_q <= 6'd0;
        end else if (data_rd_exec) begin
            address_counter_q <= ac_step(address_counter_q, step_up_q, two_line_q, glyph_sel_q);
        end else begin
            case (cmd)
                cdi_pkg::CDI_CMD_CLEAR: begin
                    address_counter_q <= `CDI_HOME_ADDR;
                    glyph_sel_q <= 1'b0;
                    step_up_q <= 1'b1;
                    shift_q <= 6'd0;
                end
                cdi_pkg::CDI_CMD_HOME: begin
                    address_counter_q <= `CDI_HOME_ADDR;
                    glyph_sel_q <= 1'b0;
                    shift_q <= 6'd0;
                end
                cdi_pkg::CDI_CMD_ENTRY: begin
                    step_up_q <= full_byte[1];
                    scroll_on_entry_q <= full_byte[0];
                end
                cdi_pkg::CDI_CMD_CONTROL: begin
                    disp_on_q <= full_byte[2];
                    cur_on_q <= full_byte[1];
                    blink_on_q <= full_byte[0];
                end
                cdi_pkg::CDI_CMD_SHIFT: begin
                    if (full_byte[3]) begin
                        shift_q <= shift_step(shift_q, !full_byte[2]);
                    end else begin
                        address_counter_q <= ac_step(address_counter_q, full_byte[2],
                            two_line_q, 1'b0);
                    end
                end
                cdi_pkg::CDI_CMD_FUNCTION: begin
                    bus_width_bit_q <= full_byte[4];
                    two_line_q <= full_byte[3];
                    font_q <= full_byte[2];
                end
                cdi_pkg::CDI_CMD_GLYPH_ADDR: begin
                    address_counter_q <= {1'b0, full_byte[5:0]};
                    glyph_sel_q <= 1'b1;
                end
                cdi_pkg::CDI_CMD_DISP_ADDR: begin
                    address_counter_q <= full_byte[6:0];
                    glyph_sel_q <= 1'b0;
                end
                cdi_pkg::CDI_CMD_DATA_WRITE: begin
                    address_counter_q <= ac_step(address_counter_q, step_up_q, two_line_q,
                        glyph_sel_q);
                    if (scroll_on_entry_q && !glyph_sel_q) begin
                        shift_q <= shift_step(shift_q, step_up_q);
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // Whole display memory is wiped in one edge, so clear holds busy for timing only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 128; i++) begin
                character_display_memory_q[i] <= `CDI_SPACE_CODE;
            end
            for (int j = 0; j < 64; j++) begin
                glyph_pattern_memory_q[j] <= 8'h00;
            end
        end else if (cmd == cdi_pkg::CDI_CMD_CLEAR) begin
            for (int i = 0; i < 128; i++) begin
                character_display_memory_q[i] <= `CDI_SPACE_CODE;
            end
        end else if (cmd == cdi_pkg::CDI_CMD_DATA_WRITE) begin
            if (glyph_sel_q) begin
                glyph_pattern_memory_q[address_counter_q[5:0]] <= full_byte;
            end else begin
                character_display_memory_q[address_counter_q] <= full_byte;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blink_cnt_q <= 32'd0;
            blink_ph_q <= 1'b0;
        end else if (!blink_on_q) begin
            blink_cnt_q <= 32'd0;
            blink_ph_q <= 1'b0;
        end else if (blink_cnt_q >= T_BLINK_CYC - 1) begin
            blink_cnt_q <= 32'd0;
            blink_ph_q <= !blink_ph_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'd1;
        end
    end

    // Read data is sampled in the address phase; no wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h00000000;
        end else if (!rd_take) begin
            hrdata_q <= 32'h00000000;
        end else if (status_rd || data_rd) begin
            hrdata_q <= bus_width_bit_q ? {24'h000000, rd_byte}
                : {24'h000000, nib_ph_q ? rd_byte[3:0] : rd_byte[7:4], 4'h0};
        end else if (haddr[7:0] == `CDI_OFS_CONFIG) begin
            hrdata_q <= {16'h0000, blink_ph_q, glyph_sel_q, shift_q, bus_width_bit_q, two_line_q,
                font_q, step_up_q, scroll_on_entry_q, disp_on_q, cur_on_q, blink_on_q};
        end else if (haddr[7:0] == `CDI_OFS_CURSOR) begin
            hrdata_q <= {16'h0000, cursor_pos, shown_char};
        end else begin
            hrdata_q <= 32'h00000000;
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule : cdi_decoder

`default_nettype wire

/* cdi_regs.svh */
// Register offsets, field positions, reset values and timing figures of the decoder
`ifndef CDI_REGS_SVH
`define CDI_REGS_SVH

`define CDI_OFS_INSTR 8'h00
`define CDI_OFS_DATA 8'h04
`define CDI_OFS_CONFIG 8'h08
`define CDI_OFS_CURSOR 8'h0c

`define CDI_CFG_BLINK 0
`define CDI_CFG_CURSOR 1
`define CDI_CFG_DISPLAY 2
`define CDI_CFG_SCROLL 3
`define CDI_CFG_STEP_UP 4
`define CDI_CFG_FONT 5
`define CDI_CFG_TWO_LINE 6
`define CDI_CFG_BUS8 7
`define CDI_CFG_SHIFT_LSB 8
`define CDI_CFG_GLYPH 14
`define CDI_CFG_PHASE 15

`define CDI_CUR_COL_LSB 8
`define CDI_CUR_ROW_LSB 13
`define CDI_CUR_VALID 15

`define CDI_SPACE_CODE 8'h20
`define CDI_HOME_ADDR 7'h00
`define CDI_LINE_COLS 7'd20
`define CDI_ROW0_BASE 7'h00
`define CDI_ROW1_BASE 7'h40
`define CDI_ROW2_BASE 7'h14
`define CDI_ROW3_BASE 7'h54
`define CDI_LINE1_LAST 7'h27
`define CDI_LINE2_FIRST 7'h40
`define CDI_LINE2_LAST 7'h67
`define CDI_ONE_LINE_LAST 7'h4f
`define CDI_SHIFT_SPAN 6'd40
`define CDI_SHIFT_LAST 6'd39

`define CDI_CLK_PERIOD_NS 10
`define CDI_T_CLEAR_NS 1530000
`define CDI_T_SHORT_NS 39000
`define CDI_T_DATA_NS 43000
`define CDI_T_BLINK_NS 400000000

`endif

/* cdi_pkg.sv */
// Types shared by the character display instruction decoder
`default_nettype none
package cdi_pkg;

    typedef enum logic [3:0] {
        CDI_CMD_NONE,
        CDI_CMD_CLEAR,
        CDI_CMD_HOME,
        CDI_CMD_ENTRY,
        CDI_CMD_CONTROL,
        CDI_CMD_SHIFT,
        CDI_CMD_FUNCTION,
        CDI_CMD_GLYPH_ADDR,
        CDI_CMD_DISP_ADDR,
        CDI_CMD_DATA_WRITE
    } cdi_cmd_t;

endpackage : cdi_pkg
`default_nettype wire

/* cdi_decoder_sva.sv */
// Port-level checker for the decoder's bus behaviour
`timescale 1ns/1ps
`default_nettype none
module cdi_decoder_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp
);
    logic rd_q;
    logic um_q;
    logic [7:0] ra_q;
    logic cw_q;
    logic drop_q;
    logic take;
    assign take = hsel && htrans[1] && hready;
    // Remember what the last address phase asked for
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            um_q <= 1'b0;
            ra_q <= 8'h00;
            cw_q <= 1'b0;
            drop_q <= 1'b0;
        end else begin
            rd_q <= take && !hwrite;
            um_q <= haddr[31:8] != 24'h000000;
            ra_q <= haddr[7:0];
            cw_q <= take && hwrite && haddr == 32'h00000000;
            drop_q <= cw_q && take && !hwrite && haddr == 32'h00000004;
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_rdata_cleared: assert property (!rd_q |-> hrdata == 32'h00000000)
        else $error("hrdata not cleared after read");
    a_rdata_upper: assert property (rd_q |-> hrdata[31:16] == 16'h0000)
        else $error("hrdata upper half not zero");
    a_unmapped_zero: assert property (rd_q && um_q |-> hrdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_shift_range: assert property (rd_q && !um_q && ra_q == 8'h08 |->
        hrdata[13:8] <= 6'd39) else $error("display shift offset above 39");
    a_cursor_col: assert property (rd_q && !um_q && ra_q == 8'h0c && hrdata[15] |->
        hrdata[12:8] <= 5'd19) else $error("cursor column above 19");
    a_drop_after: assert property (drop_q |-> hrdata == 32'h00000000)
        else $error("data read after command not dropped");
endmodule : cdi_decoder_sva
bind cdi_decoder cdi_decoder_sva chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
`default_nettype wire

/* cdi_host_model.sv */
// Host model: AHB-Lite master speaking the decoder's byte protocol
`timescale 1ns/1ps
`default_nettype none
module cdi_host_model (
    input wire logic hclk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    output logic hang
);
    logic nib_mode = 1'b0;
    initial begin
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        hang = 1'b0;
    end
    task automatic edge_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) hang <= 1'b1;
    endtask : edge_ready
    // Stale write data is inverted, never left looking valid
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hwdata <= ~hwdata;
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_ready();
        q = hrdata;
    endtask : xfer
    // Command write whose data phase carries a data read address
    task automatic wr_then_rd(input logic [7:0] c, output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= 32'h00000000;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        edge_ready();
        haddr <= 32'h00000004;
        hwrite <= 1'b0;
        hwdata <= {24'h000000, c};
        edge_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        edge_ready();
        q = hrdata;
    endtask : wr_then_rd
    // Offset picks target, high nibble first
    task automatic put_byte(input logic ts, input logic [7:0] b);
        logic [31:0] q;
        if (nib_mode) begin
            xfer(1'b1, {29'h0, ts, 2'b00}, {24'h000000, b[7:4], 4'h0}, q);
            xfer(1'b1, {29'h0, ts, 2'b00}, {24'h000000, b[3:0], 4'h0}, q);
        end else begin
            xfer(1'b1, {29'h0, ts, 2'b00}, {24'h000000, b}, q);
        end
        if (ts == 1'b0 && b[7:5] == 3'b001) nib_mode = ~b[4];
    endtask : put_byte
    // Read nibbles arrive on upper lines
    task automatic get_byte(input logic ts, output logic [7:0] b);
        logic [31:0] q;
        xfer(1'b0, {29'h0, ts, 2'b00}, 32'h00000000, q);
        b = q[7:0];
        if (nib_mode) begin
            b[7:4] = q[7:4];
            xfer(1'b0, {29'h0, ts, 2'b00}, 32'h00000000, q);
            b[3:0] = q[7:4];
        end
    endtask : get_byte
    // Poll busy, then spare one cycle
    task automatic wait_idle();
        logic [7:0] s;
        int n;
        n = 0;
        do begin
            get_byte(1'b0, s);
            n++;
        end while (s[7] !== 1'b0 && n < 200);
        if (s[7] !== 1'b0) hang <= 1'b1;
        @(posedge hclk);
    endtask : wait_idle
    task automatic instr(input logic ts, input logic [7:0] b);
        wait_idle();
        put_byte(ts, b);
    endtask : instr
endmodule : cdi_host_model
`default_nettype wire

/* tb_char_display_instruction_decoder.sv */
// Self-checking bench: host model plus integer reference state
`timescale 1ns/1ps
`default_nettype none
module tb_char_display_instruction_decoder;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel, hwrite, hready, hreadyout, hresp, hang;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] b, lfsr_q = 8'h09;
    logic [7:0] mem [128];
    logic m_two, m_up, m_scr;
    int err_count = 0;
    int total_checks = 0;
    int m_ac, m_shift;
    logic [7:0] fs [4] = '{8'h30, 8'h34, 8'h3c, 8'h38};
    logic [7:0] sc [5] = '{8'h10, 8'h14, 8'h18, 8'h1c, 8'h18};
    logic [6:0] pa [8] = '{7'h00, 7'h13, 7'h40, 7'h53, 7'h14, 7'h27, 7'h54, 7'h67};
    always #5 hclk = ~hclk;
    assign hready = hreadyout;
    // Short busy counts keep the run brief
    cdi_decoder #(.T_CLEAR_CYC(20), .T_SHORT_CYC(5), .T_DATA_CYC(6), .T_BLINK_CYC(8)) dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp));
    cdi_host_model host_u (.hclk(hclk), .hready(hready), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hang(hang));
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic final_report();
        $display("Checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    always @(posedge hang) begin
        err_count++;
        final_report();
    end
    function automatic logic [7:0] nrand();
        lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        return lfsr_q;
    endfunction : nrand
    // Wrap points differ by line mode
    function automatic int nx(int a);
        if (m_two) return a == 39 ? 64 : (a == 103 ? 0 : a + 1);
        return a == 79 ? 0 : a + 1;
    endfunction : nx
    task automatic rr(input logic [31:0] a);
        host_u.xfer(1'b0, a, 32'h00000000, q);
    endtask : rr
    task automatic st(input string name);
        host_u.wait_idle();
        host_u.get_byte(1'b0, b);
        chk(name, {24'h0, b}, 32'(m_ac));
    endtask : st
    task automatic sa(input logic [6:0] a);
        host_u.instr(1'b0, {1'b1, a});
        m_ac = a;
    endtask : sa
    task automatic ent(input logic [7:0] e);
        host_u.instr(1'b0, e);
        m_up = e[1];
        m_scr = e[0];
    endtask : ent
    task automatic dw();
        logic [7:0] d;
        d = nrand();
        host_u.instr(1'b1, d);
        mem[m_ac] = d;
        if (m_scr) m_shift = (m_shift + (m_up ? 1 : 39)) % 40;
        m_ac = m_up ? nx(m_ac) : m_ac - 1;
    endtask : dw
    task automatic drd(input string name);
        host_u.wait_idle();
        host_u.get_byte(1'b1, b);
        chk(name, {24'h0, b}, {24'h0, mem[m_ac]});
        m_ac = m_up ? nx(m_ac) : m_ac - 1;
    endtask : drd
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        m_ac = 0;
        m_shift = 0;
        m_up = 1'b1;
        m_scr = 1'b0;
        m_two = 1'b0;
        rr(32'h08);
        chk("config reset", q & 32'h7fff, 32'h0090);
        st("status reset");
        host_u.put_byte(1'b0, 8'h01);
        host_u.get_byte(1'b0, b);
        chk("busy", {31'h0, b[7]}, 32'h1);
        host_u.put_byte(1'b1, 8'h41);
        foreach (mem[i]) mem[i] = 8'h20;
        st("clear counter");
        drd("clear space");
        st("read step");
        $display("Test clear done");
        ent(8'h04);
        sa(7'h10);
        dw();
        st("decrement");
        ent(8'h06);
        dw();
        st("increment");
        ent(8'h07);
        dw();
        rr(32'h08);
        chk("scroll left", {26'h0, q[13:8]}, 32'(m_shift));
        drd("read no scroll");
        ent(8'h05);
        dw();
        rr(32'h08);
        chk("scroll right", {26'h0, q[13:8]}, 32'(m_shift));
        host_u.instr(1'b0, 8'h45);
        host_u.instr(1'b1, 8'h55);
        m_ac = 4;
        st("glyph step");
        rr(32'h08);
        chk("glyph no scroll", {26'h0, q[13:8]}, 32'(m_shift));
        ent(8'h06);
        $display("Test entry done");
        foreach (fs[i]) begin
            host_u.instr(1'b0, fs[i]);
            m_two = fs[i][3];
            rr(32'h08);
            chk("function", {29'h0, q[7:5]}, {29'h0, fs[i][4:2]});
        end
        sa(7'h27);
        dw();
        st("wrap line one");
        sa(7'h67);
        dw();
        st("wrap line two");
        host_u.instr(1'b0, 8'h30);
        m_two = 1'b0;
        sa(7'h4f);
        dw();
        st("wrap one line");
        host_u.instr(1'b0, 8'h38);
        m_two = 1'b1;
        $display("Test function done");
        sa(7'h20);
        foreach (sc[i]) begin
            host_u.instr(1'b0, sc[i]);
            if (!sc[i][3]) m_ac = sc[i][2] ? m_ac + 1 : m_ac - 1;
            else m_shift = (m_shift + (sc[i][2] ? 39 : 1)) % 40;
            st("shift counter");
            rr(32'h08);
            chk("shift offset", {26'h0, q[13:8]}, 32'(m_shift));
        end
        dw();
        host_u.instr(1'b0, 8'h02);
        m_ac = 0;
        m_shift = 0;
        st("home counter");
        rr(32'h08);
        chk("home shift", {26'h0, q[13:8]}, 32'h0);
        sa(7'h20);
        drd("home keeps memory");
        $display("Test shift done");
        for (int k = 8; k < 16; k++) begin
            host_u.instr(1'b0, 8'(k));
            rr(32'h08);
            chk("control", {27'h0, q[4:0]}, {27'h0, 2'b10, k[2:0]});
        end
        foreach (pa[i]) begin
            sa(pa[i]);
            rr(32'h0c);
            chk("place", {24'h0, q[15:8]}, {24'h0, 1'b1, 2'(i / 2), 5'(i % 2 * 19)});
        end
        $display("Test screen done");
        host_u.instr(1'b0, 8'h28);
        rr(32'h08);
        chk("four bit", {31'h0, q[7]}, 32'h0);
        sa(7'h05);
        dw();
        sa(7'h05);
        drd("nibble data");
        st("nibble status");
        host_u.instr(1'b0, 8'h38);
        rr(32'h08);
        chk("eight bit", {31'h0, q[7]}, 32'h1);
        host_u.xfer(1'b1, 32'h100, 32'hff, q);
        rr(32'h100);
        chk("unmapped", q, 32'h0);
        host_u.xfer(1'b1, 32'h08, 32'h0, q);
        rr(32'h08);
        chk("config kept", {24'h0, q[7:0]}, 32'hd7);
        host_u.wait_idle();
        host_u.wr_then_rd(8'h06, q);
        chk("dropped read", q, 32'h0);
        $display("Test bus done");
        final_report();
    end
endmodule : tb_char_display_instruction_decoder
`default_nettype wire
